//--- rtl/pwm_pkg.sv
package pwm_pkg;
  // ****************************************
  // Channel and output mapping
  // ****************************************
  localparam int unsigned NUM_CHANNELS   = 4;
  localparam int unsigned FIRST_OUT_PIN  = 5;
  localparam int unsigned LAST_OUT_PIN   = 8;
  localparam int unsigned PIN_COUNT      = 9;
  // ****************************************
  // Operand ranges
  // ****************************************
  localparam logic [13:0] DUTY_FULL      = 14'h2710;
  localparam logic [15:0] FREQ_MIN_HZ    = 16'h0001;
  localparam logic [15:0] FREQ_MAX_HZ    = 16'hc350;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned PERIOD_W       = 27;
  localparam int unsigned FRAC_W         = 32;
  localparam logic [26:0] RESET_PERIOD   = 27'h0000000;
  localparam logic [26:0] RESET_ON_TIME  = 27'h0000000;
  localparam logic [2:0]  DIV_LATENCY    = 3'h0;
endpackage : pwm_pkg

//--- rtl/pwm_divider.sv
module pwm_divider #(
  parameter int unsigned N_W = 48,
  parameter int unsigned D_W = 16
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  // Request
  input  wire logic             start_i,
  input  wire logic [N_W-1:0]   num_i,
  input  wire logic [D_W-1:0]   den_i,
  // Answer
  output logic                  busy_o,
  output logic                  done_o,
  output logic [N_W-1:0]        quot_o
);
  initial begin
    if (N_W < 2 || D_W < 1) $error("pwm_divider widths too small");
  end

  logic [N_W-1:0]     quot;
  logic [D_W:0]       rem;
  logic [D_W-1:0]     den;
  logic [$clog2(N_W+1)-1:0] cnt;
  logic [D_W:0]       trial;

  assign trial  = {rem[D_W-1:0], quot[N_W-1]};
  assign busy_o = cnt != '0;

  // Restoring division, one quotient bit per cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      quot   <= '0;
      rem    <= '0;
      den    <= '0;
      cnt    <= '0;
      done_o <= 1'b0;
      quot_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        quot <= num_i;
        rem  <= '0;
        den  <= den_i;
        cnt  <= ($clog2(N_W+1))'(N_W);
      end else if (busy_o) begin
        if (trial >= {1'b0, den}) begin
          rem  <= trial - {1'b0, den};
          quot <= {quot[N_W-2:0], 1'b1};
        end else begin
          rem  <= trial;
          quot <= {quot[N_W-2:0], 1'b0};
        end
        cnt <= cnt - 1'b1;
        if (cnt == 1) begin
          done_o <= 1'b1;
          quot_o <= (trial >= {1'b0, den}) ? {quot[N_W-2:0], 1'b1} : {quot[N_W-2:0], 1'b0};
        end
      end
    end
  end
endmodule // pwm_divider

//--- rtl/four_channel_pwm_outputs.sv
// Contract
// - Four independent channels, each holding its own frequency and duty.
// - Channel 1 drives digital output 5 up to channel 4 on output 8.
// - Frequency programmable continuously from 1 Hz to 50 kHz.
// - Frequency error below 0.5 percent at 10 kHz, 0.01 percent low.
// - One set command carries channel, duty and frequency together.
// - Duty counts hundredths of a percent, 0 to 10000.
// - At 50 Hz duty steps of 0.01 percent are resolved.
// - Duty is on-time over period; period is reciprocal of frequency.
module four_channel_pwm_outputs #(
  parameter int unsigned CLK_HZ = pwm_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // Set command
  input  wire logic        set_pulse_width_command_valid_i,
  output logic             set_pulse_width_command_ready_o,
  input  wire logic [1:0]  set_pulse_width_command_channel_i,
  input  wire logic [13:0] set_pulse_width_command_duty_i,
  input  wire logic [15:0] set_pulse_width_command_freq_i,
  output logic             set_pulse_width_command_error_o,
  // Digital outputs, index is the pin number
  output logic [pwm_pkg::PIN_COUNT-1:0] digital_out_o
);
  localparam int unsigned NCH = pwm_pkg::NUM_CHANNELS;
  localparam int unsigned PW  = pwm_pkg::PERIOD_W;

  // Limits that the fixed port widths and pin map rely on
  initial begin
    if (CLK_HZ < 2 * 50_000 || CLK_HZ >= (1 << PW)) $error("CLK_HZ out of range for period counter");
    if (NCH > 4) $error("channel field too narrow for NCH");
    if (pwm_pkg::FIRST_OUT_PIN + NCH - 1 != pwm_pkg::LAST_OUT_PIN) $error("pin map does not match NCH");
    if (pwm_pkg::LAST_OUT_PIN >= pwm_pkg::PIN_COUNT) $error("pin map exceeds output port");
  end

  // ****************************************
  // Command path state
  // ****************************************
  typedef enum logic [1:0] {IDLE, DIV_PERIOD, DIV_ON} cmd_state_t;

  cmd_state_t       state;
  logic [1:0]       cmd_ch;
  logic [13:0]      cmd_duty;
  logic [15:0]      cmd_freq;
  logic [PW-1:0]    new_period;
  logic             div_start;
  logic             div_busy;
  logic             div_done;
  logic [47:0]      div_num;
  logic [15:0]      div_den;
  logic [47:0]      div_quot;
  logic             cmd_ok;

  // ****************************************
  // Channel settings
  // ****************************************
  // Staged settings, loaded at the period boundary
  logic [PW-1:0]    pend_period [NCH];
  logic [PW-1:0]    pend_on     [NCH];
  logic [NCH-1:0]   pend_valid;
  logic [PW-1:0]    act_period  [NCH];
  logic [PW-1:0]    act_on      [NCH];
  logic [PW-1:0]    phase       [NCH];
  logic [NCH-1:0]   wave;
  logic [NCH-1:0]   load_now;

  // ****************************************
  // Shared helpers
  // ****************************************
  // Last clock of a running period; the only point where a running
  // channel may load a new setting, so pulses are never cut short
  function automatic logic last_phase(input logic [PW-1:0] ph, input logic [PW-1:0] per);
    return ph == per - 1'b1;
  endfunction

  // Range check happens before anything is stored
  assign cmd_ok = set_pulse_width_command_freq_i >= pwm_pkg::FREQ_MIN_HZ
               && set_pulse_width_command_freq_i <= pwm_pkg::FREQ_MAX_HZ
               && set_pulse_width_command_duty_i <= pwm_pkg::DUTY_FULL;
  assign set_pulse_width_command_ready_o = state == IDLE;

  // ****************************************
  // Command intake and period arithmetic
  // ****************************************
  // Rounded integer divisions keep error below one clock per period
  // Period times duty stays below 2**48 for every legal operand
  always_comb begin
    div_start = 1'b0;
    div_num   = '0;
    div_den   = 16'h0001;
    if (state == IDLE && set_pulse_width_command_valid_i && cmd_ok) begin
      div_start = 1'b1;
      div_num   = 48'(CLK_HZ) + 48'(set_pulse_width_command_freq_i >> 1);
      div_den   = set_pulse_width_command_freq_i;
    end else if (state == DIV_PERIOD && div_done) begin
      div_start = 1'b1;
      div_num   = 48'(div_quot[PW-1:0]) * 48'(cmd_duty) + 48'(pwm_pkg::DUTY_FULL >> 1);
      div_den   = 16'(pwm_pkg::DUTY_FULL);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state                           <= IDLE;
      cmd_ch                          <= '0;
      cmd_duty                        <= '0;
      cmd_freq                        <= '0;
      new_period                      <= '0;
      set_pulse_width_command_error_o <= 1'b0;
    end else begin
      set_pulse_width_command_error_o <= 1'b0;
      unique case (state)
        // Refused commands raise error only and store nothing
        IDLE: begin
          if (set_pulse_width_command_valid_i) begin
            if (cmd_ok) begin
              cmd_ch   <= set_pulse_width_command_channel_i;
              cmd_duty <= set_pulse_width_command_duty_i;
              cmd_freq <= set_pulse_width_command_freq_i;
              state    <= DIV_PERIOD;
            end else begin
              set_pulse_width_command_error_o <= 1'b1;
            end
          end
        end
        DIV_PERIOD: begin
          if (div_done) begin
            new_period <= div_quot[PW-1:0];
            state      <= DIV_ON;
          end
        end
        DIV_ON: begin
          if (div_done) begin
            state <= IDLE;
          end
        end
        // Unused code: fall back to idle rather than stall
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // One divider serves both steps; ready stays low until both finish
  pwm_divider #(
    .N_W (48),
    .D_W (16)
  ) u_div (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .start_i    (div_start),
    .num_i      (div_num),
    .den_i      (div_den),
    .busy_o     (div_busy),
    .done_o     (div_done),
    .quot_o     (div_quot)
  );

  // ****************************************
  // Per-channel generators
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Idle channel (period zero) picks up a setting at once
    assign load_now[c] = pend_valid[c] && (act_period[c] == '0 || last_phase(phase[c], act_period[c]));

    // A write in the loading cycle wins; the last command to a channel wins
    always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
        pend_period[c] <= pwm_pkg::RESET_PERIOD;
        pend_on[c]     <= pwm_pkg::RESET_ON_TIME;
        pend_valid[c]  <= 1'b0;
      end else if (state == DIV_ON && div_done && cmd_ch == 2'(c)) begin
        pend_period[c] <= new_period;
        pend_on[c]     <= div_quot[PW-1:0];
        pend_valid[c]  <= 1'b1;
      end else if (load_now[c]) begin
        pend_valid[c]  <= 1'b0;
      end
    end

    // Phase runs only while a period is set; idle channels hold zero
    always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
        act_period[c] <= pwm_pkg::RESET_PERIOD;
        act_on[c]     <= pwm_pkg::RESET_ON_TIME;
        phase[c]      <= '0;
      end else if (load_now[c]) begin
        act_period[c] <= pend_period[c];
        act_on[c]     <= pend_on[c];
        phase[c]      <= '0;
      end else if (act_period[c] != '0) begin
        phase[c] <= last_phase(phase[c], act_period[c]) ? '0 : phase[c] + 1'b1;
      end
    end

    // On during the first act_on clocks of each period
    // Registered one step ahead so the pin needs no decode
    always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
        wave[c] <= 1'b0;
      end else if (load_now[c]) begin
        wave[c] <= pend_on[c] != '0;
      end else begin
        wave[c] <= act_period[c] != '0
                && (last_phase(phase[c], act_period[c]) ? (act_on[c] != '0) : (phase[c] + 1'b1 < act_on[c]));
      end
    end
  end

  // ****************************************
  // Output pin mapping
  // ****************************************
  // Pins without a channel stay low
  always_comb begin
    digital_out_o = '0;
    for (int i = 0; i < NCH; i++) begin
      digital_out_o[pwm_pkg::FIRST_OUT_PIN + i] = wave[i];
    end
  end
endmodule // four_channel_pwm_outputs

//--- verif/pwm_outputs_assertions.sv
module pwm_outputs_checker (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        set_pulse_width_command_valid_i,
  input wire logic        set_pulse_width_command_ready_o,
  input wire logic [1:0]  set_pulse_width_command_channel_i,
  input wire logic [13:0] set_pulse_width_command_duty_i,
  input wire logic [15:0] set_pulse_width_command_freq_i,
  input wire logic        set_pulse_width_command_error_o,
  input wire logic [8:0]  digital_out_o
);
  logic take;
  logic bad;
  assign take = set_pulse_width_command_valid_i && set_pulse_width_command_ready_o;
  assign bad  = set_pulse_width_command_freq_i == 16'h0000 ||
                set_pulse_width_command_freq_i > pwm_pkg::FREQ_MAX_HZ ||
                set_pulse_width_command_duty_i > pwm_pkg::DUTY_FULL;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_spare_pins_low: assert property (digital_out_o[4:0] == 5'h00)
    else $error("spare pins driven");
  a_bad_cmd_error: assert property (take && bad |=> set_pulse_width_command_error_o)
    else $error("bad command not flagged");
  a_good_cmd_quiet: assert property (take && !bad |=> !set_pulse_width_command_error_o)
    else $error("good command flagged");
  a_good_cmd_busy: assert property (take && !bad |=> !set_pulse_width_command_ready_o ##[1:150] set_pulse_width_command_ready_o)
    else $error("busy window wrong");
  a_error_has_cause: assert property (set_pulse_width_command_error_o |-> $past(take && bad))
    else $error("error without bad command");
  a_bad_keeps_ready: assert property (take && bad |=> set_pulse_width_command_ready_o)
    else $error("bad command made block busy");
  a_reset_pins_low: assert property ($past(reset_i) |-> digital_out_o == 9'h000)
    else $error("pins not low after reset");
  a_reset_ready: assert property ($past(reset_i) |-> set_pulse_width_command_ready_o)
    else $error("not ready after reset");
endmodule // pwm_outputs_checker

bind four_channel_pwm_outputs pwm_outputs_checker i_checker (.core_clk_i, .reset_i,
  .set_pulse_width_command_valid_i, .set_pulse_width_command_ready_o, .set_pulse_width_command_channel_i,
  .set_pulse_width_command_duty_i, .set_pulse_width_command_freq_i, .set_pulse_width_command_error_o,
  .digital_out_o);

//--- verif/pwm_load.sv
module pwm_load (
  input  wire logic        clk_i,
  input  wire logic        pin_i,
  output logic      [31:0] high_o,
  output logic      [31:0] period_o,
  output logic      [31:0] rises_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        prev = 1'b0;
  logic [31:0] cnt  = 32'h0;
  logic [31:0] hcnt = 32'h0;
  initial begin
    high_o = 32'h0;
    period_o = 32'h0;
    rises_o = 32'h0;
  end
  // Period and on-time measured between rising edges
  always @(posedge clk_i) begin
    prev <= pin_i;
    if (pin_i && !prev) begin
      period_o <= cnt;
      high_o <= hcnt;
      rises_o <= rises_o + 32'h1;
      cnt <= 32'h1;
      hcnt <= 32'h1;
    end else begin
      cnt <= cnt + 32'h1;
      hcnt <= hcnt + {31'h0, pin_i};
    end
  end
endmodule // pwm_load

//--- verif/four_channel_pwm_outputs_bench.sv
module four_channel_pwm_outputs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Slow clock model keeps 50 Hz periods short
  localparam int unsigned CLK = 500_000;
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, ready, err;
  logic [1:0] ch = 2'h0;
  logic [13:0] duty = 14'h0000;
  logic [15:0] freq = 16'h0000;
  logic [8:0] dout;
  logic [31:0] hi_m[4], per_m[4], rise_m[4];
  int failures = 0, check_count = 0, cycles = 0;
  logic e;
  logic [31:0] r2, r3;
  typedef struct {logic [1:0] c; logic [13:0] d; logic [15:0] f; logic [31:0] p; logic [31:0] h;} row_t;
  row_t rows[4] = '{'{2'h0, 14'h01f5, 16'h0032, 32'd10000, 32'd501}, '{2'h1, 14'h0bb8, 16'h2710, 32'd50, 32'd15},
                    '{2'h2, 14'h1388, 16'hc350, 32'd10, 32'd5}, '{2'h3, 14'h251c, 16'h03e8, 32'd500, 32'd475}};
  four_channel_pwm_outputs #(.CLK_HZ(CLK)) i_dut (.core_clk_i(clk), .reset_i(rst),
    .set_pulse_width_command_valid_i(valid), .set_pulse_width_command_ready_o(ready),
    .set_pulse_width_command_channel_i(ch), .set_pulse_width_command_duty_i(duty),
    .set_pulse_width_command_freq_i(freq), .set_pulse_width_command_error_o(err), .digital_out_o(dout));
  for (genvar g = 0; g < 4; g++) begin : g_load
    pwm_load i_load (.clk_i(clk), .pin_i(dout[g+5]), .high_o(hi_m[g]), .period_o(per_m[g]), .rises_o(rise_m[g]));
  end
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic send(input logic [1:0] c, input logic [13:0] d, input logic [15:0] f);
    int n;
    n = 0;
    @(negedge clk);
    {valid, ch, duty, freq} = {1'b1, c, d, f};
    while (ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("ready before take", n < 300, 1'b1);
    @(negedge clk);
    valid = 1'b0;
    e = err;
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("ready after take", n < 300, 1'b1);
  endtask
  task automatic wait_rises(input int i, input int k);
    logic [31:0] base;
    int n;
    base = rise_m[i];
    n = 0;
    while (rise_m[i] < base + k && n < 40000) begin
      @(negedge clk);
      n++;
    end
    check("rise wait", n < 40000, 1'b1);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    send(2'h0, 14'h01f4, 16'h0000);
    check("zero freq err", e, 1'b1);
    send(2'h0, 14'h01f4, 16'hc351);
    check("high freq err", e, 1'b1);
    send(2'h0, 14'h2711, 16'h0032);
    check("high duty err", e, 1'b1);
    $display("test refusals done");
    foreach (rows[i]) begin
      send(rows[i].c, rows[i].d, rows[i].f);
      check("good err", e, 1'b0);
      wait_rises(i, 3);
      check("period", per_m[i], rows[i].p);
      check("on time", hi_m[i], rows[i].h);
    end
    $display("test table done");
    send(2'h1, 14'h1770, 16'h2710);
    wait_rises(1, 3);
    check("new period", per_m[1], 32'd50);
    check("new on time", hi_m[1], 32'd30);
    $display("test update done");
    send(2'h3, 14'h0000, 16'h03e8);
    send(2'h2, 14'h2710, 16'hc350);
    repeat (1100) @(negedge clk);
    {r2, r3} = {rise_m[2], rise_m[3]};
    repeat (600) @(negedge clk);
    check("full duty pin", dout[7], 1'b1);
    check("zero duty pin", dout[8], 1'b0);
    check("no rises full", rise_m[2], r2);
    check("no rises zero", rise_m[3], r3);
    check("other channel kept", per_m[0], 32'd10000);
    check("other on time kept", hi_m[1], 32'd30);
    $display("test extremes done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check("reset pins", dout, 9'h000);
    check("reset ready", ready, 1'b1);
    rst = 1'b0;
    send(2'h0, 14'h1388, 16'hc350);
    check("after reset err", e, 1'b0);
    wait_rises(0, 3);
    check("after reset period", per_m[0], 32'd10);
    check("after reset on time", hi_m[0], 32'd5);
    $display("test reset done");
    end_of_test();
  end
endmodule // four_channel_pwm_outputs_bench
